//--- inc/asr_consts.svh
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASR_OFS_CTRL       8'h00
`define ASR_OFS_STAT       8'h04
`define ASR_OFS_DATA       8'h08
`define ASR_OFS_BAUD       8'h0C
`define ASR_OFS_ISTS       8'h10
`define ASR_OFS_IMSK       8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASR_CTRL_SERIAL_PORT_ENABLE      0
`define ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE      1
`define ASR_STAT_RXF       0
`define ASR_STAT_OVR       1
`define ASR_STAT_IDLE      2
`define ASR_STAT_STUCK     3
`define ASR_STAT_FERR      4
`define ASR_IRQ_RX         0
`define ASR_IRQ_OVR        1
`define ASR_IRQ_IDLE       2
`define ASR_IRQ_FERR       3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASR_DIV_RST        16'h0001
`define ASR_IMSK_RST       4'h0

// ----------------------------------------------------------------
// Timing in sixteenths of a bit period
// ----------------------------------------------------------------
`define ASR_GLITCH_CHK     4'h1
`define ASR_IDLE_BACK      4'h2
`define ASR_MID_BIT        4'h8
`define ASR_LAST_TICK      4'hF

`endif

//--- inc/asr_pkg.sv
package asr_pkg;

	// Receiver sequencing states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_GLITCH,
		ST_WAIT2,
		ST_STUCK,
		ST_DATA,
		ST_STOP
	} asr_state_t;

	// Decoded register selection
	typedef enum logic [2:0] {
		R_CTRL,
		R_STAT,
		R_DATA,
		R_BAUD,
		R_ISTS,
		R_IMSK,
		R_NONE
	} asr_reg_t;

endpackage

//--- rtl/asr_tick_gen.sv
// Oversampling tick: one pulse every divisor+1 clocks while running
module asr_tick_gen #(
	parameter int DIV_W = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  tick
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} asr_tick_t;

	asr_tick_t r_ff;
	asr_tick_t nxt_r;

	generate
		if (DIV_W < 1) begin : g_bad_width
			$error("asr_tick_gen: DIV_W must be at least 1");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	// Counter held at zero while stopped so each start is aligned
	always_comb begin
		nxt_r = r_ff;
		nxt_r.tick = 1'b0;
		if (!run) begin
			nxt_r.cnt = '0;
		end else if (r_ff.cnt >= divisor) begin
			nxt_r.cnt = '0;
			nxt_r.tick = 1'b1;
		end else begin
			nxt_r.cnt = r_ff.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign tick = r_ff.tick;

endmodule // asr_tick_gen

//--- rtl/asr_status_flags.sv
// Overview of operation
// RULE_01: Overrun flag clears only on receive enable low or device reset.
// RULE_02: Turning the serial port off leaves the overrun flag untouched.
// RULE_03: Idle flag drops when a start edge appears on the line.
// RULE_04: After an isolated invalid start, idle returns high 1/8 bit later.
// RULE_05: Second glitch within a bit: idle stays high, falls one bit later.
// RULE_06: After that fall, idle stays low until a valid start bit.
// RULE_07: Serial port enable low resets the receiver and restores idle.
// RULE_08: Software times idle-low to receive flag; resets module if too long.
// RULE_09: Software clears overrun by dropping receive enable, not port enable.
// RULE_10: A char finishing while data is unread sets overrun and is dropped.

`include "asr_consts.svh"

module asr_status_flags #(
	parameter int DATA_BITS = 8,
	parameter int DIV_W     = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_line,
	output logic             irq
);

	localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);

	generate
		if (DATA_BITS < 5 || DATA_BITS > 9) begin : g_bad_bits
			$error("asr_status_flags: DATA_BITS must be 5 to 9");
		end
		if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
			$error("asr_status_flags: DIV_W must be 1 to 16");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		asr_pkg::asr_state_t  st;
		logic [3:0]           tcnt;
		logic [3:0]           bcnt;
		logic [3:0]           wcnt;
		logic                 win;
		logic                 stuck;
		logic                 idle;
		logic                 line_q;
		logic [DATA_BITS-1:0] shift;
		logic [DATA_BITS-1:0] rx_data;
		logic                 rx_full;
		logic                 ovr;
		logic                 ferr;
		logic                 serial_port_enable;
		logic                 continuous_receive_enable;
		logic [DIV_W-1:0]     div;
		logic [3:0]           ists;
		logic [3:0]           imsk;
		logic [31:0]          rdata;
	} asr_core_t;

	asr_core_t           r_ff;
	asr_core_t           nxt_r;
	logic                tick;
	logic                fall;
	logic                acc;
	logic                setup;
	logic [3:0]          ev;
	logic [3:0]          clr;
	logic [3:0]          nt;
	asr_pkg::asr_reg_t   sel;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic asr_pkg::asr_reg_t dec(input logic [7:0] a);
		case (a)
			`ASR_OFS_CTRL: dec = asr_pkg::R_CTRL;
			`ASR_OFS_STAT: dec = asr_pkg::R_STAT;
			`ASR_OFS_DATA: dec = asr_pkg::R_DATA;
			`ASR_OFS_BAUD: dec = asr_pkg::R_BAUD;
			`ASR_OFS_ISTS: dec = asr_pkg::R_ISTS;
			`ASR_OFS_IMSK: dec = asr_pkg::R_IMSK;
			default:       dec = asr_pkg::R_NONE;
		endcase
	endfunction

	// APB phase qualifiers and zero-wait answer
	assign sel     = dec(paddr);
	assign setup   = psel & ~penable;
	assign acc     = psel & penable;
	assign pready  = 1'b1;
	assign pslverr = acc & (sel == asr_pkg::R_NONE);
	assign prdata  = r_ff.rdata;
	assign irq     = |(r_ff.ists & r_ff.imsk);

	// Falling edge of the receive line
	assign fall = r_ff.line_q & ~rx_line;
	assign nt   = r_ff.tcnt + 4'h1;

	// ----------------------------------------------------------------
	// Oversampling clock, stopped while the port is off
	// ----------------------------------------------------------------
	asr_tick_gen #(
		.DIV_W   (DIV_W)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (r_ff.serial_port_enable),
		.divisor (r_ff.div),
		.tick    (tick)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_r = r_ff;
		ev = 4'h0;
		clr = 4'h0;
		nxt_r.line_q = rx_line;

		// Register writes and read-side effects at the access edge
		if (acc && pwrite) begin
			case (sel)
				asr_pkg::R_CTRL: begin
					nxt_r.serial_port_enable = pwdata[`ASR_CTRL_SERIAL_PORT_ENABLE];
					nxt_r.continuous_receive_enable = pwdata[`ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE];
				end
				asr_pkg::R_BAUD: nxt_r.div = pwdata[DIV_W-1:0];
				asr_pkg::R_ISTS: clr = pwdata[3:0];
				asr_pkg::R_IMSK: nxt_r.imsk = pwdata[3:0];
				default: ;
			endcase
		end
		if (acc && !pwrite && sel == asr_pkg::R_DATA) begin
			nxt_r.rx_full = 1'b0;
		end

		// Read data captured in the setup cycle
		if (setup) begin
			nxt_r.rdata = 32'h0;
			case (sel)
				asr_pkg::R_CTRL: begin
					nxt_r.rdata[`ASR_CTRL_SERIAL_PORT_ENABLE] = r_ff.serial_port_enable;
					nxt_r.rdata[`ASR_CTRL_CONTINUOUS_RECEIVE_ENABLE] = r_ff.continuous_receive_enable;
				end
				asr_pkg::R_STAT: begin
					nxt_r.rdata[`ASR_STAT_RXF]   = r_ff.rx_full;
					nxt_r.rdata[`ASR_STAT_OVR]   = r_ff.ovr;
					nxt_r.rdata[`ASR_STAT_IDLE]  = r_ff.idle;
					nxt_r.rdata[`ASR_STAT_STUCK] = r_ff.stuck;
					nxt_r.rdata[`ASR_STAT_FERR]  = r_ff.ferr;
				end
				asr_pkg::R_DATA: nxt_r.rdata[DATA_BITS-1:0] = r_ff.rx_data;
				asr_pkg::R_BAUD: nxt_r.rdata[DIV_W-1:0] = r_ff.div;
				asr_pkg::R_ISTS: nxt_r.rdata[3:0] = r_ff.ists;
				asr_pkg::R_IMSK: nxt_r.rdata[3:0] = r_ff.imsk;
				default: ;
			endcase
		end

		// Overrun cleared only by receive enable low or device reset
		if (!r_ff.continuous_receive_enable) begin
			nxt_r.ovr = 1'b0; // RULE_01
		end

		// Glitch window measured from the first leading edge
		if (r_ff.win && tick) begin
			nxt_r.wcnt = r_ff.wcnt + 4'h1;
			if (r_ff.wcnt == `ASR_LAST_TICK) begin
				nxt_r.win = 1'b0;
			end
		end

		// Receiver sequencing
		if (!r_ff.serial_port_enable) begin
			// Port off: receiver back to rest, overrun kept
			nxt_r.st = asr_pkg::ST_IDLE; // RULE_07
			nxt_r.idle = 1'b1; // RULE_07
			nxt_r.stuck = 1'b0;
			nxt_r.win = 1'b0;
			nxt_r.tcnt = 4'h0;
			nxt_r.bcnt = 4'h0;
			nxt_r.rx_full = 1'b0; // RULE_02
		end else if (!r_ff.continuous_receive_enable && (r_ff.st == asr_pkg::ST_START ||
			r_ff.st == asr_pkg::ST_DATA || r_ff.st == asr_pkg::ST_STOP)) begin
			// Reception disabled mid-character: abandon it
			nxt_r.st = r_ff.stuck ? asr_pkg::ST_STUCK : asr_pkg::ST_IDLE;
			nxt_r.idle = ~r_ff.stuck;
		end else begin
			case (r_ff.st)
				asr_pkg::ST_IDLE: begin
					if (fall && r_ff.continuous_receive_enable) begin
						nxt_r.tcnt = 4'h0;
						if (r_ff.win) begin
							// Second edge inside the window
							nxt_r.st = asr_pkg::ST_WAIT2; // RULE_05
							nxt_r.win = 1'b0;
						end else begin
							nxt_r.st = asr_pkg::ST_START;
							nxt_r.idle = 1'b0; // RULE_03
							nxt_r.win = 1'b1;
							nxt_r.wcnt = 4'h0;
						end
					end
				end
				asr_pkg::ST_START: begin
					if (tick) begin
						nxt_r.tcnt = nt;
						if (rx_line && nt >= `ASR_GLITCH_CHK) begin
							// Line back high before mid-bit: invalid start
							nxt_r.st = r_ff.stuck ? asr_pkg::ST_STUCK :
								asr_pkg::ST_GLITCH;
						end else if (nt == `ASR_MID_BIT) begin
							// Valid start bit
							nxt_r.st = asr_pkg::ST_DATA;
							nxt_r.tcnt = 4'h0;
							nxt_r.bcnt = 4'h0;
							nxt_r.stuck = 1'b0; // RULE_06
							nxt_r.win = 1'b0;
						end
					end
				end
				asr_pkg::ST_GLITCH: begin
					if (fall && r_ff.continuous_receive_enable && r_ff.win) begin
						// Back-to-back glitch: idle reads high meanwhile
						nxt_r.st = asr_pkg::ST_WAIT2; // RULE_05
						nxt_r.idle = 1'b1; // RULE_05
						nxt_r.tcnt = 4'h0;
						nxt_r.win = 1'b0;
					end else if (tick) begin
						nxt_r.tcnt = nt;
						if (nt >= `ASR_IDLE_BACK) begin
							nxt_r.st = asr_pkg::ST_IDLE;
							nxt_r.idle = 1'b1; // RULE_04
						end
					end
				end
				asr_pkg::ST_WAIT2: begin
					if (tick) begin
						nxt_r.tcnt = nt;
						if (r_ff.tcnt == `ASR_LAST_TICK) begin
							// One bit period later the flag falls
							nxt_r.st = asr_pkg::ST_STUCK;
							nxt_r.idle = 1'b0; // RULE_05
							nxt_r.stuck = 1'b1; // RULE_06
						end
					end
				end
				asr_pkg::ST_STUCK: begin
					// Idle held low; only a valid start or turning the port off releases it
					if (fall && r_ff.continuous_receive_enable) begin
						nxt_r.st = asr_pkg::ST_START; // RULE_06
						nxt_r.tcnt = 4'h0;
					end
				end
				asr_pkg::ST_DATA: begin
					if (tick) begin
						nxt_r.tcnt = nt;
						if (r_ff.tcnt == `ASR_LAST_TICK) begin
							// Sample at bit centre, LSB first
							nxt_r.shift = {rx_line,
								r_ff.shift[DATA_BITS-1:1]};
							nxt_r.bcnt = r_ff.bcnt + 4'h1;
							if (r_ff.bcnt == LAST_BIT) begin
								nxt_r.st = asr_pkg::ST_STOP;
							end
						end
					end
				end
				asr_pkg::ST_STOP: begin
					if (tick) begin
						nxt_r.tcnt = nt;
						if (r_ff.tcnt == `ASR_LAST_TICK) begin
							nxt_r.st = asr_pkg::ST_IDLE;
							nxt_r.idle = 1'b1;
							if (nxt_r.rx_full) begin
								// Unread data kept, new char dropped
								nxt_r.ovr = 1'b1; // RULE_10
								ev[`ASR_IRQ_OVR] = 1'b1; // RULE_10
							end else begin
								nxt_r.rx_data = r_ff.shift;
								nxt_r.rx_full = 1'b1;
								nxt_r.ferr = ~rx_line;
								ev[`ASR_IRQ_RX] = 1'b1;
								ev[`ASR_IRQ_FERR] = ~rx_line;
							end
						end
					end
				end
				default: begin
					nxt_r.st = asr_pkg::ST_IDLE;
					nxt_r.idle = 1'b1;
				end
			endcase
		end

		// Idle falling edge is an event for software timing
		ev[`ASR_IRQ_IDLE] = r_ff.idle & ~nxt_r.idle; // RULE_08

		// Sticky events, set wins over write-one-to-clear
		nxt_r.ists = (r_ff.ists & ~clr) | ev;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
			r_ff.idle <= 1'b1;
			r_ff.line_q <= 1'b1;
			r_ff.div <= DIV_W'(`ASR_DIV_RST);
			r_ff.imsk <= `ASR_IMSK_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

endmodule // asr_status_flags

//--- tb/asr_properties.sv
`include "asr_consts.svh"

module asr_properties #(
	parameter int DATA_BITS = 8,
	parameter int DIV_W     = 16
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_line,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Helper state
	// ------------------------------------------------------------
	logic       acc;
	logic       map;
	logic       st_rd;
	logic       ovr_seen;
	logic       serial_port_enable_ff;
	logic [1:0] age;

	// Access phase and address decode
	assign acc   = psel && penable;
	assign map   = (paddr[1:0] == 2'h0) && (paddr <= `ASR_OFS_IMSK);
	assign st_rd = acc && !pwrite && (paddr == `ASR_OFS_STAT);

	// Tracks a seen overrun and the port enable written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_seen <= 1'b0;
			serial_port_enable_ff  <= 1'b0;
			age      <= 2'h0;
		end else begin
			if (st_rd && prdata[1])
				ovr_seen <= 1'b1;
			if (acc && pwrite && paddr == `ASR_OFS_CTRL) begin
				if (!pwdata[1])
					ovr_seen <= 1'b0;
				serial_port_enable_ff <= pwdata[0];
				age     <= 2'h0;
			end else if (age != 2'h3)
				age <= age + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence off_read;
		(!serial_port_enable_ff && age >= 2'h2) ##0 st_rd;
	endsequence

	ready_zero_wait_a: assert property (acc |-> pready)
		else $error("pready low in access phase");
	err_decode_a: assert property (acc |-> pslverr == !map)
		else $error("pslverr disagrees with decode");
	err_quiet_a: assert property (!acc |-> !pslverr)
		else $error("pslverr outside access phase");
	err_data_zero_a: assert property (acc && !map && !pwrite |-> prdata == 0)
		else $error("unmapped read data not zero");
	data_stands_a: assert property (!$past(psel && !penable) |-> $stable(prdata))
		else $error("read data moved outside setup");
	irq_reset_low_a: assert property ($rose(presetn) |-> !irq)
		else $error("irq high after reset");
	irq_clear_cause_a: assert property ($fell(irq) |->
		$past(acc && pwrite) || $past(acc && pwrite, 2))
		else $error("irq fell without a write");
	ovr_sticky_a: assert property (
		st_rd && ovr_seen |-> prdata[1])
		else $error("overrun flag lost");
	port_off_idle_a: assert property (off_read |->
		prdata[3:2] == 2'h1 && !prdata[0])
		else $error("idle not restored with port off");
endmodule // asr_properties

bind asr_status_flags asr_properties #(
	.DATA_BITS(DATA_BITS),
	.DIV_W(DIV_W)
) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx_line(rx_line), .irq(irq)
);

//--- tb/asr_tx_model.sv
module asr_tx_model #(
	parameter int BIT_CLKS = 64
) (
	input  wire logic pclk,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// Line rests high between frames
	initial rx_line = 1'b1;

	// Short low pulse of n clocks, then back to the idle level
	task automatic pulse(input int n);
		rx_line <= 1'b0;
		repeat (n) @(posedge pclk);
		rx_line <= 1'b1;
	endtask

	// One frame: start bit, data LSB first, one stop bit
	// A low stop bit is followed by one bit of idle level
	task automatic send(input logic [7:0] b, input logic stop = 1'b1);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (BIT_CLKS) @(posedge pclk);
		end
		if (!stop) begin
			rx_line <= 1'b1;
			repeat (BIT_CLKS) @(posedge pclk);
		end
	endtask
endmodule // asr_tx_model

//--- tb/test_async_receiver_status_flags.sv
`include "asr_consts.svh"

module test_async_receiver_status_flags;
	timeunit 1ns;
	timeprecision 100ps;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic        pready;
	logic        pslverr;
	logic        rx_line;
	logic        irq;
	logic        err;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	// Clock and hang guard
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	asr_status_flags #(.DATA_BITS(8), .DIV_W(16)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_line(rx_line), .irq(irq)
	);

	// Remote sender, bit of 64 clocks with divisor 3
	asr_tx_model #(.BIT_CLKS(64)) tx (.pclk(pclk), .rx_line(rx_line));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input string n, input logic [7:0] a,
		input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rdat & m);
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd("ctrl", `ASR_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		rd("status", `ASR_OFS_STAT, 32'h1F, 32'h4);
		rd("baud", `ASR_OFS_BAUD, 32'hFFFF, 32'h1);
		rd("mask", `ASR_OFS_IMSK, 32'hF, 32'h0);
		rd("hole", 8'h18, 32'hFFFFFFFF, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, `ASR_OFS_STAT, 32'hFF);
		rd("ro status", `ASR_OFS_STAT, 32'h1F, 32'h4);
		chk("no slverr", 32'h0, {31'h0, err});
	endtask

	task automatic t_overrun;
		apb(1'b1, `ASR_OFS_BAUD, 32'h3);
		apb(1'b1, `ASR_OFS_CTRL, 32'h3);
		tx.send(8'hA5);
		tx.send(8'h3C);
		rd("overrun", `ASR_OFS_STAT, 32'h3, 32'h3);
		rd("kept char", `ASR_OFS_DATA, 32'hFF, 32'hA5);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `ASR_OFS_IMSK, 32'h2);
		chk("irq on", 32'h1, {31'h0, irq});
		apb(1'b1, `ASR_OFS_ISTS, 32'hF);
		chk("irq off", 32'h0, {31'h0, irq});
		apb(1'b1, `ASR_OFS_CTRL, 32'h2);
		rd("port off", `ASR_OFS_STAT, 32'h2, 32'h2);
		apb(1'b1, `ASR_OFS_CTRL, 32'h3);
		rd("port on", `ASR_OFS_STAT, 32'h2, 32'h2);
		apb(1'b1, `ASR_OFS_CTRL, 32'h1);
		rd("continuous_receive_enable off", `ASR_OFS_STAT, 32'h2, 32'h0);
		// Frame with a low stop bit is stored with its framing error
		apb(1'b1, `ASR_OFS_CTRL, 32'h3);
		tx.send(8'hC3, 1'b0);
		rd("ferr", `ASR_OFS_STAT, 32'h13, 32'h11);
		rd("ferr char", `ASR_OFS_DATA, 32'hFF, 32'hC3);
		rd("ferr event", `ASR_OFS_ISTS, 32'h9, 32'h9);
	endtask

	// Device reset in mid-run clears a pending overrun
	task automatic t_rst_ovr;
		apb(1'b1, `ASR_OFS_CTRL, 32'h3);
		tx.send(8'h11);
		tx.send(8'h22);
		rd("ovr set", `ASR_OFS_STAT, 32'h2, 32'h2);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("ovr reset", `ASR_OFS_STAT, 32'h1F, 32'h4);
	endtask

	task automatic dbl;
		tx.pulse(2);
		repeat (20) @(posedge pclk);
		tx.pulse(2);
	endtask

	task automatic t_glitch;
		apb(1'b1, `ASR_OFS_CTRL, 32'h3);
		apb(1'b1, `ASR_OFS_ISTS, 32'hF);
		tx.pulse(2);
		rd("idle low", `ASR_OFS_STAT, 32'h4, 32'h0);
		repeat (20) @(posedge pclk);
		rd("idle back", `ASR_OFS_STAT, 32'hC, 32'h4);
		rd("idle fell", `ASR_OFS_ISTS, 32'h4, 32'h4);
		repeat (80) @(posedge pclk);
		dbl();
		rd("idle held", `ASR_OFS_STAT, 32'h4, 32'h4);
		repeat (80) @(posedge pclk);
		rd("idle stuck", `ASR_OFS_STAT, 32'hC, 32'h8);
		repeat (300) @(posedge pclk);
		rd("still stuck", `ASR_OFS_STAT, 32'hC, 32'h8);
		tx.send(8'h5A);
		rd("valid start", `ASR_OFS_STAT, 32'hD, 32'h5);
		rd("char", `ASR_OFS_DATA, 32'hFF, 32'h5A);
		dbl();
		repeat (80) @(posedge pclk);
		apb(1'b1, `ASR_OFS_CTRL, 32'h2);
		rd("port reset", `ASR_OFS_STAT, 32'hD, 32'h4);
	endtask

	// Reset, then run the scenarios
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_overrun();
		t_glitch();
		t_rst_ovr();
		stop_test();
	end
endmodule // test_async_receiver_status_flags
